// *** dv/occ_pin_load.sv ***
module occ_pin_load (
	input wire logic pin_out,
	input wire logic pin_oe_n,
	output logic pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	// Board pull-down: a released pin reads low, never the last driven level
	assign pin_level = pin_oe_n ? 1'b0 : pin_out;
endmodule // occ_pin_load

// *** dv/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import occ_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	occ_bus_req_t bus = '0;
	occ_timers_t tm = '0;
	logic cpu_idle = 1'b0;
	logic flt_n = 1'b1;
	logic [CMP_W-1:0] rdata;
	logic pin_out;
	logic pin_oe_n;
	logic irq;
	logic pin_level;
	logic rd_seen = 1'b0;
	logic cur = 1'b0;
	logic [1:0] st = 2'h0;
	logic [CMP_W-1:0] exp_q[$];
	int failures = 0;
	int n_compared = 0;

	initial begin
		forever #4 mclk = ~mclk;
	end

	occ_channel dut_u (.mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata), .timers(tm),
		.cpu_idle(cpu_idle), .fault_input_a_n(flt_n), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .irq(irq));
	occ_pin_load load_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));

	task automatic cmp(logic [CMP_W-1:0] got, logic [CMP_W-1:0] exp, string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic final_report();
		if (failures == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		rd_seen <= bus.rd;
	end

	// Read data stands one cycle only, zero at all other times
	always @(negedge mclk) begin
		if (rd_seen) begin
			cmp(rdata, exp_q.pop_front(), "read data");
		end else if (!reset) begin
			cmp(rdata, 16'h0000, "idle read data");
		end
	end

	// For a read, d is the expected word
	task automatic acc(logic r, logic [ADDR_W-1:0] a, logic [CMP_W-1:0] d);
		@(posedge mclk);
		bus <= {a, d, ~r, r};
		if (r) exp_q.push_back(d);
		@(posedge mclk);
		bus <= '0;
	endtask

	task automatic step(logic sel, logic [CMP_W-1:0] v);
		@(posedge mclk);
		if (sel) tm.t3 <= v;
		else tm.t2 <= v;
		repeat (3) @(posedge mclk);
	endtask

	task automatic chk();
		@(negedge mclk);
		cmp({15'h0, pin_level}, {15'h0, cur}, "pin level");
		cmp({15'h0, pin_oe_n}, 16'h0000, "pin enable");
		cmp({15'h0, irq}, {15'h0, |st}, "irq");
		// Hand back on a rising edge so the next stimulus lands there
		@(posedge mclk);
	endtask

	function automatic logic nxt(logic [2:0] m, logic c, logic on_p);
		case (m)
			3'h1: return on_p | c;
			3'h2: return c & ~on_p;
			3'h3: return c ^ on_p;
			// PWM: primary match ends the duty
			3'h6: return c & ~on_p;
			default: return on_p;
		endcase
	endfunction

	task automatic event_at(logic sel, logic [CMP_W-1:0] v, logic on_p, logic [2:0] m);
		logic n;
		step(sel, v);
		n = nxt(m, cur, on_p);
		// PWM edges never raise the compare event
		if (m != 3'h6 && n != cur && (m == 3'h3 || (m == 3'h1) == n)) st[0] = 1'b1;
		cur = n;
		chk();
	endtask

	initial begin
		logic [CMP_W-1:0] p;
		logic [2:0] m;
		logic ts;
		p = 16'($urandom(67));
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		for (int a = 0; a < 8; a++) acc(1'b1, a[2:0], 16'h0000);
		@(negedge mclk);
		cmp({15'h0, pin_oe_n}, 16'h0001, "disabled enable");
		acc(1'b0, OFS_CTRL, 16'hFFFF);
		acc(1'b1, OFS_CTRL, 16'h200F);
		acc(1'b0, OFS_CTRL, 16'h0000);
		acc(1'b0, OFS_MASK, 16'hFFFF);
		acc(1'b1, OFS_MASK, 16'h0003);
		for (int i = 1; i < 6; i++) begin
			m = i[2:0];
			// First pass pins the second timer; the PWM runs below use the first
			ts = (i == 1) ? 1'b1 : 1'($urandom % 2);
			p = 16'($urandom_range(32767, 1));
			cpu_idle <= 1'($urandom % 2);
			acc(1'b0, OFS_PRI, p);
			acc(1'b0, OFS_SEC, p ^ 16'h8000);
			acc(1'b0, OFS_CTRL, {12'h0, ts, m});
			repeat (3) @(posedge mclk);
			cur = (m == 3'h2);
			chk();
			step(~ts, p);
			chk();
			for (int k = 0; k < 2; k++) begin
				// A spent one-shot must hold low like a finished set-low shot
				m = (i == 4 && k == 1) ? 3'h2 : i[2:0];
				event_at(ts, p, 1'b1, m);
				event_at(ts, p ^ 16'h8000, 1'b0, m);
				event_at(ts, 16'h0000, 1'b0, m);
			end
			acc(1'b1, OFS_STAT, {14'h0, st});
			acc(1'b0, OFS_STAT, 16'h0003);
			st = 2'h0;
			acc(1'b1, OFS_CTRL, {12'h0, ts, i[2:0]});
			acc(1'b0, OFS_CTRL, 16'h0000);
			tm <= '0;
		end
		cpu_idle <= 1'b0;
		p = 16'($urandom_range(32767, 1));
		acc(1'b0, OFS_PRI, p);
		acc(1'b0, OFS_CTRL, 16'h0006);
		repeat (3) @(posedge mclk);
		cur = 1'b1;
		chk();
		event_at(1'b0, p, 1'b1, 3'h6);
		step(1'b0, 16'h0000);
		cur = 1'b1;
		chk();
		flt_n <= 1'b0;
		repeat (6) @(posedge mclk);
		chk();
		flt_n <= 1'b1;
		repeat (4) @(posedge mclk);
		acc(1'b0, OFS_CTRL, 16'h0007);
		repeat (3) @(posedge mclk);
		chk();
		flt_n <= 1'b0;
		repeat (6) @(posedge mclk);
		cur = 1'b0;
		st = 2'h2;
		chk();
		acc(1'b1, OFS_CTRL, 16'h0017);
		flt_n <= 1'b1;
		repeat (4) @(posedge mclk);
		acc(1'b1, OFS_CTRL, 16'h0007);
		acc(1'b1, OFS_STAT, 16'h0002);
		acc(1'b0, OFS_STAT, 16'h0002);
		st = 2'h0;
		acc(1'b0, OFS_CTRL, 16'h0000);
		acc(1'b0, OFS_PRI, 16'h0000);
		acc(1'b0, OFS_CTRL, 16'h0006);
		repeat (3) @(posedge mclk);
		cur = 1'b0;
		chk();
		acc(1'b0, OFS_CTRL, 16'h0000);
		acc(1'b0, OFS_PRI, p);
		cpu_idle <= 1'b1;
		acc(1'b0, OFS_CTRL, 16'h2001);
		repeat (3) @(posedge mclk);
		step(1'b0, p);
		chk();
		cpu_idle <= 1'b0;
		step(1'b0, 16'h0000);
		event_at(1'b0, p, 1'b1, 3'h1);
		final_report();
	end

	// Hang guard
	initial begin
		#100000;
		failures++;
		final_report();
	end
endmodule // testbench

// *** pkg/occ_pkg.sv ***
package occ_pkg;

	localparam int CMP_W = 16;
	localparam int ADDR_W = 3;

	// Register word offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_PRI = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_SEC = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_STAT = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_MASK = 3'h4;

	// Control register fields
	localparam int CTL_MODE_LO = 0;
	localparam int CTL_MODE_HI = 2;
	localparam int CTL_TSEL_BIT = 3;
	localparam int CTL_FLT_BIT = 4;
	localparam int CTL_IDLE_BIT = 13;

	// Interrupt status and mask fields
	localparam int IRQ_W = 2;
	localparam int IRQ_CMP_BIT = 0;
	localparam int IRQ_FLT_BIT = 1;

	// Reset values
	localparam logic [CMP_W-1:0] CMP_RST = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
	localparam logic [CMP_W-1:0] RDATA_RST = 16'h0000;

	typedef enum logic [2:0] {
		MODE_OFF = 3'h0,
		MODE_SET_HI = 3'h1,
		MODE_SET_LO = 3'h2,
		MODE_TOGGLE = 3'h3,
		MODE_DELAYED = 3'h4,
		MODE_CONT = 3'h5,
		MODE_PWM_NF = 3'h6,
		MODE_PWM_F = 3'h7
	} occ_mode_t;

	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_ARM = 4'h2,
		ST_HIGH = 4'h4,
		ST_DONE = 4'h8
	} occ_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [CMP_W-1:0] wdata;
		logic wr;
		logic rd;
	} occ_bus_req_t;

	typedef struct packed {
		logic [CMP_W-1:0] t2;
		logic [CMP_W-1:0] t3;
	} occ_timers_t;

endpackage

// *** verilog/occ_channel.sv ***
// Local design decisions: the address-and-strobe port and the register addresses.
module occ_channel
	import occ_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire occ_pkg::occ_bus_req_t bus,
	output logic [occ_pkg::CMP_W-1:0] rdata,
	input wire occ_pkg::occ_timers_t timers,
	input wire logic cpu_idle,
	input wire logic fault_input_a_n,
	output logic pin_out,
	output logic pin_oe_n,
	output logic irq
);
	import occ_pkg::*;

	occ_mode_t mode_r;
	occ_mode_t mode_prev_r;
	occ_state_t state_r;
	occ_state_t state_nxt;
	logic tsel_r;
	logic idle_stop_r;
	logic flt_r;
	logic [CMP_W-1:0] pri_r;
	logic [CMP_W-1:0] sec_r;
	logic [IRQ_W-1:0] stat_r;
	logic [IRQ_W-1:0] mask_r;
	logic [IRQ_W-1:0] evt;
	logic [CMP_W-1:0] rdata_r;
	logic pin_r;
	logic pin_nxt;
	logic oe_n_r;
	logic flt_n_s;
	logic flt_n_d_r;
	logic pri_hit;
	logic sec_hit;
	logic wrap_hit;
	logic mode_chg;
	logic run;
	logic rise;
	logic fall;
	logic cmp_evt;
	logic flt_evt;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic init_level(input occ_mode_t m, input logic cur,
		input logic [CMP_W-1:0] pri);
		case (m)
			MODE_SET_LO: init_level = 1'b1;
			MODE_TOGGLE: init_level = cur;
			MODE_PWM_NF, MODE_PWM_F: init_level = (pri != '0);
			default: init_level = 1'b0;
		endcase
	endfunction

	occ_sync #(.RST_VAL(1'b1)) u_flt_sync (
		.mclk(mclk),
		.reset(reset),
		.d(fault_input_a_n),
		.q(flt_n_s)
	);

	occ_match #(.W(CMP_W)) u_match (
		.mclk(mclk),
		.reset(reset),
		.tsel(tsel_r),
		.t2(timers.t2),
		.t3(timers.t3),
		.pri(pri_r),
		.sec(sec_r),
		.pri_hit(pri_hit),
		.sec_hit(sec_hit),
		.wrap_hit(wrap_hit)
	);

	assign run = !(idle_stop_r && cpu_idle);
	assign mode_chg = (mode_r != mode_prev_r);

	// Control register; the fault flag bit is not writable
	always_ff @(posedge mclk) begin
		if (reset) begin
			mode_r <= MODE_OFF;
			tsel_r <= 1'b0;
			idle_stop_r <= 1'b0;
		end else if (bus.wr && hit(bus.addr, OFS_CTRL)) begin
			mode_r <= occ_mode_t'(bus.wdata[CTL_MODE_HI:CTL_MODE_LO]);
			tsel_r <= bus.wdata[CTL_TSEL_BIT];
			idle_stop_r <= bus.wdata[CTL_IDLE_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pri_r <= CMP_RST;
			sec_r <= CMP_RST;
		end else if (bus.wr) begin
			if (hit(bus.addr, OFS_PRI))
				pri_r <= bus.wdata;
			if (hit(bus.addr, OFS_SEC))
				sec_r <= bus.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset)
			mode_prev_r <= MODE_OFF;
		else
			mode_prev_r <= mode_r;
	end

	// Output sequencing
	always_comb begin
		pin_nxt = pin_r;
		state_nxt = state_r;
		if (mode_r == MODE_OFF) begin
			pin_nxt = 1'b0;
			state_nxt = ST_OFF;
		end else if (mode_chg) begin
			pin_nxt = init_level(mode_r, pin_r, pri_r);
			state_nxt = ST_ARM;
		end else if (run) begin
			case (mode_r)
				MODE_SET_HI, MODE_SET_LO: begin
					if (state_r == ST_ARM && pri_hit) begin
						pin_nxt = (mode_r == MODE_SET_HI);
						state_nxt = ST_DONE;
					end
				end
				MODE_TOGGLE: begin
					if (pri_hit)
						pin_nxt = !pin_r;
				end
				MODE_DELAYED, MODE_CONT: begin
					case (state_r)
						ST_ARM: begin
							if (pri_hit) begin
								pin_nxt = 1'b1;
								state_nxt = ST_HIGH;
							end
						end
						ST_HIGH: begin
							if (sec_hit) begin
								pin_nxt = 1'b0;
								// Continuous re-arms for the next timer period
								state_nxt = (mode_r == MODE_CONT) ? ST_ARM : ST_DONE;
							end
						end
						default: state_nxt = state_r;
					endcase
				end
				MODE_PWM_NF, MODE_PWM_F: begin
					// Primary match wins at wrap, so a zero duty stays low
					if (pri_hit)
						pin_nxt = 1'b0;
					else if (wrap_hit)
						pin_nxt = 1'b1;
				end
				default: pin_nxt = pin_r;
			endcase
		end
		// Fault protection acts even while halted in idle
		if (mode_r == MODE_PWM_F && !mode_chg && !flt_n_s)
			pin_nxt = 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_r <= 1'b0;
			state_r <= ST_OFF;
			oe_n_r <= 1'b1;
		end else begin
			pin_r <= pin_nxt;
			state_r <= state_nxt;
			oe_n_r <= (mode_r == MODE_OFF);
		end
	end

	assign pin_out = pin_r;
	assign pin_oe_n = oe_n_r;

	// Fault flag follows the synchronised input, only in mode 111
	always_ff @(posedge mclk) begin
		if (reset) begin
			flt_r <= 1'b0;
			flt_n_d_r <= 1'b1;
		end else begin
			flt_n_d_r <= flt_n_s;
			flt_r <= (mode_r == MODE_PWM_F) && !flt_n_s;
		end
	end

	// Interrupt events
	assign rise = pin_nxt && !pin_r && !mode_chg;
	assign fall = !pin_nxt && pin_r && !mode_chg;
	always_comb begin
		case (mode_r)
			MODE_SET_HI: cmp_evt = rise;
			MODE_SET_LO: cmp_evt = fall;
			MODE_TOGGLE: cmp_evt = rise || fall;
			MODE_DELAYED, MODE_CONT: cmp_evt = fall;
			default: cmp_evt = 1'b0;
		endcase
	end
	assign flt_evt = (mode_r == MODE_PWM_F) && flt_n_d_r && !flt_n_s;
	assign evt = {flt_evt, cmp_evt};

	// Status: write one clears, a same-cycle event still sets
	always_ff @(posedge mclk) begin
		if (reset) begin
			stat_r <= IRQ_RST;
			mask_r <= IRQ_RST;
		end else begin
			if (bus.wr && hit(bus.addr, OFS_STAT))
				stat_r <= (stat_r & ~bus.wdata[IRQ_W-1:0]) | evt;
			else
				stat_r <= stat_r | evt;
			if (bus.wr && hit(bus.addr, OFS_MASK))
				mask_r <= bus.wdata[IRQ_W-1:0];
		end
	end

	assign irq = |(stat_r & mask_r);

	// Read port: data valid only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata_r <= RDATA_RST;
		end else begin
			rdata_r <= RDATA_RST;
			if (bus.rd) begin
				if (hit(bus.addr, OFS_CTRL)) begin
					rdata_r[CTL_MODE_HI:CTL_MODE_LO] <= mode_r;
					rdata_r[CTL_TSEL_BIT] <= tsel_r;
					rdata_r[CTL_FLT_BIT] <= flt_r;
					rdata_r[CTL_IDLE_BIT] <= idle_stop_r;
				end else if (hit(bus.addr, OFS_PRI)) begin
					rdata_r <= pri_r;
				end else if (hit(bus.addr, OFS_SEC)) begin
					rdata_r <= sec_r;
				end else if (hit(bus.addr, OFS_STAT)) begin
					rdata_r[IRQ_W-1:0] <= stat_r;
				end else if (hit(bus.addr, OFS_MASK)) begin
					rdata_r[IRQ_W-1:0] <= mask_r;
				end
			end
		end
	end

	assign rdata = rdata_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	off_gpio_a: assert property ((mode_r == MODE_OFF) |=> pin_oe_n
		&& (!stat_r[IRQ_CMP_BIT] || $past(stat_r[IRQ_CMP_BIT])))
		else $error("disabled channel drives pin or raises event");
	set_high_a: assert property ((mode_r == MODE_SET_HI && state_r == ST_ARM && pri_hit
		&& run && !mode_chg) |=> pin_r && stat_r[IRQ_CMP_BIT] && state_r == ST_DONE)
		else $error("active-low one-shot did not rise with interrupt");
	set_low_a: assert property ((mode_r == MODE_SET_LO && state_r == ST_ARM && pri_hit
		&& run && !mode_chg) |=> !pin_r && stat_r[IRQ_CMP_BIT])
		else $error("active-high one-shot did not fall with interrupt");
	toggle_pin_a: assert property ((mode_r == MODE_TOGGLE && pri_hit && run && !mode_chg)
		|=> pin_r != $past(pin_r) && stat_r[IRQ_CMP_BIT])
		else $error("toggle mode did not invert pin");
	delayed_end_a: assert property ((mode_r == MODE_DELAYED && state_r == ST_HIGH && sec_hit
		&& run && !mode_chg) |=> !pin_r && state_r == ST_DONE ##1 state_r == ST_DONE)
		else $error("delayed one-shot did not end after one pulse");
	cont_rearm_a: assert property ((mode_r == MODE_CONT && state_r == ST_HIGH && sec_hit
		&& run && !mode_chg) |=> !pin_r && state_r == ST_ARM)
		else $error("continuous pulse did not re-arm");
	pwm_init_a: assert property ((mode_r == MODE_PWM_NF && mode_chg)
		|=> pin_r == ($past(pri_r) != '0))
		else $error("PWM initial level wrong");
	pwm_noirq_a: assert property ((mode_r == MODE_PWM_NF) |-> evt == '0)
		else $error("PWM without fault raised an event");
	fault_hold_a: assert property ((mode_r == MODE_PWM_F && !mode_chg && !flt_n_s)
		|=> !pin_r && flt_r)
		else $error("fault did not force pin low and set flag");
	fault_clear_a: assert property ((flt_r && (flt_n_s || mode_r != MODE_PWM_F))
		|=> !flt_r)
		else $error("fault flag did not clear");
	idle_halt_a: assert property ((!run && !mode_chg && mode_r != MODE_OFF
		&& mode_r != MODE_PWM_F) |=> $stable(pin_r))
		else $error("pin moved while halted in idle");
	unimpl_zero_a: assert property ((bus.rd && hit(bus.addr, OFS_CTRL))
		|=> rdata[15:14] == 2'h0 && rdata[12:5] == 8'h00)
		else $error("unimplemented control bits read nonzero");

	oneshot_done_c: cover property (mode_r == MODE_DELAYED && state_r == ST_HIGH ##[1:50]
		state_r == ST_DONE);
	cont_two_c: cover property (mode_r == MODE_CONT && cmp_evt ##[1:200] cmp_evt);
	fault_irq_c: cover property (flt_evt ##1 irq);
	toggle_c: cover property (mode_r == MODE_TOGGLE && rise ##[1:100] fall);
endmodule // occ_channel

// *** verilog/occ_match.sv ***
module occ_match #(
	parameter int W = 16
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic tsel,
	input wire logic [W-1:0] t2,
	input wire logic [W-1:0] t3,
	input wire logic [W-1:0] pri,
	input wire logic [W-1:0] sec,
	output logic pri_hit,
	output logic sec_hit,
	output logic wrap_hit
);
	logic [W-1:0] cnt;
	logic [W-1:0] cnt_prev_r;
	logic moved;

	generate
		if (W < 2) begin : g_bad_w
			$error("occ_match: W must be at least 2");
		end
	endgenerate

	assign cnt = tsel ? t3 : t2;
	// A prescaled timer holds a value many cycles; hit only on arrival
	assign moved = (cnt != cnt_prev_r);

	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt_prev_r <= '0;
			pri_hit <= 1'b0;
			sec_hit <= 1'b0;
			wrap_hit <= 1'b0;
		end else begin
			cnt_prev_r <= cnt;
			pri_hit <= moved && (cnt == pri);
			sec_hit <= moved && (cnt == sec);
			wrap_hit <= moved && (cnt == '0);
		end
	end

	sel_timer_a: assert property (@(posedge mclk) disable iff (reset)
		pri_hit |-> $past((tsel ? t3 : t2) == pri))
		else $error("compare hit without selected timer match");
endmodule // occ_match

// *** verilog/occ_sync.sv ***
module occ_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic d,
	output logic q
);
	logic meta_r;

	// Only the second stage is visible outside
	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // occ_sync
